// ### hw/bru_consts.vh
// Constants of the byte rotate unit: offsets, fields, reset values, opcodes
// Functional notes
// - Rotate left without carry wraps bit seven
// - Rotate left destination: zero W, one file
// - Rotate right through carry via C flag
// - Rotate right destination: zero W, one file
// - Access select zero uses the access bank
// - Access select one uses bank select register
// - Extended set, a zero, f<=95: indexed literal offset
// - Rotate left through carry via C flag
`ifndef BRU_CONSTS_VH
`define BRU_CONSTS_VH

// ====================================================================
// Register byte offsets
`define BRU_OFF_INSTR      8'h00
`define BRU_OFF_WORK       8'h04
`define BRU_OFF_STATUS     8'h08
`define BRU_OFF_BANK_SEL   8'h0C
`define BRU_OFF_CTRL       8'h10
`define BRU_OFF_INDEX_BASE 8'h14
`define BRU_OFF_MEM_ADDR   8'h18
`define BRU_OFF_MEM_DATA   8'h1C
`define BRU_OFF_EFF_ADDR   8'h20

// ====================================================================
// Status bit positions
`define BRU_ST_C     0
`define BRU_ST_Z     1
`define BRU_ST_N     2
`define BRU_ST_BADOP 7
// Control bit positions
`define BRU_CTRL_EXT 0

// ====================================================================
// Reset values
`define BRU_RST_WORK   8'h00
`define BRU_RST_STATUS 8'h00
`define BRU_RST_BANK   4'h0
`define BRU_RST_CTRL   8'h00
`define BRU_RST_INDEX  12'h000

// ====================================================================
// Instruction fields and opcodes (upper six bits)
`define BRU_OPC_HI      15
`define BRU_OPC_LO      10
`define BRU_BIT_D       9
`define BRU_BIT_A       8
`define BRU_OPC_RLNC    6'h11
`define BRU_OPC_RRC     6'h0C
`define BRU_OPC_RLC     6'h0D
// Operation selects
`define BRU_OP_NONE     2'h0
`define BRU_OP_RLNC     2'h1
`define BRU_OP_RRC      2'h2
`define BRU_OP_RLC      2'h3

// ====================================================================
// Addressing
`define BRU_IDX_LIMIT   8'h5F
`define BRU_ACC_SPLIT   8'h60
`define BRU_ACC_HI_BANK 4'hF

`endif

// ### hw/bru_rotate.v
// Combinational rotate datapath with flag generation
`timescale 1ns/1ps
`include "bru_consts.vh"

module bru_rotate
(
  // Operation select and operands
  input  wire [1:0] op,
  input  wire [7:0] operand,
  input  wire       carry_in,
  // Result and flags
  output reg  [7:0] result,
  output reg        carry_out,
  output wire       neg_flag,
  output wire       zero_flag
);

  // ==================================================================
  // Rotate selection
  always @*
  begin
    result    = operand;
    carry_out = carry_in;
    case (op)
      `BRU_OP_RLNC:
      begin
        // Old bit seven wraps to bit zero
        result = {operand[6:0], operand[7]};
      end
      `BRU_OP_RRC:
      begin
        // Bit zero to carry, carry to bit seven
        result    = {carry_in, operand[7:1]};
        carry_out = operand[0];
      end
      `BRU_OP_RLC:
      begin
        // Bit seven to carry, carry to bit zero
        result    = {operand[6:0], carry_in};
        carry_out = operand[7];
      end
      default:
      begin
        result    = operand;
        carry_out = carry_in;
      end
    endcase
  end

  // Negative and zero from the result
  assign neg_flag  = result[7];
  assign zero_flag = (result == 8'h00);

endmodule

// ### hw/bru_top.v
// APB-accessed rotate unit with file memory and bank addressing
`timescale 1ns/1ps
`include "bru_consts.vh"

module bru_top
#(
  parameter ADDR_W = 12              // File memory address width
)
(
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB request
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  // APB answer
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);

  // One byte per file address
  localparam DEPTH = 1 << ADDR_W;    // File memory depth

  // ==================================================================
  // Functions

  // Opcode decode to operation select
  // Codes other than the three rotates decode to no operation
  function [1:0] op_decode;
    input [15:0] ins;
    begin
      case (ins[`BRU_OPC_HI:`BRU_OPC_LO])
        `BRU_OPC_RLNC: op_decode = `BRU_OP_RLNC;
        `BRU_OPC_RRC:  op_decode = `BRU_OP_RRC;
        `BRU_OPC_RLC:  op_decode = `BRU_OP_RLC;
        default:       op_decode = `BRU_OP_NONE;
      endcase
    end
  endfunction

  // Effective file address from access bit and bank state
  // Access bank: low 96 bytes of bank 0 and high 160 bytes of bank 15
  // Literal offset sum wraps within the file memory
  function [ADDR_W-1:0] eff_addr;
    input              acc;
    input [7:0]        fa;
    input [3:0]        bank;
    input              ext;
    input [ADDR_W-1:0] base;
    begin
      if (acc)
        eff_addr = {bank, fa};
      else if (ext && fa <= `BRU_IDX_LIMIT)
        eff_addr = base + {{(ADDR_W-8){1'b0}}, fa};
      else if (fa < `BRU_ACC_SPLIT)
        eff_addr = {4'h0, fa};
      else
        eff_addr = {`BRU_ACC_HI_BANK, fa};
    end
  endfunction

  // ==================================================================
  // State
  // File memory has no reset; operands must be loaded before use
  reg  [7:0]        mem [0:DEPTH-1];  // File register memory
  reg  [15:0]       instr_reg;        // Last instruction word
  reg               pend_reg;         // Instruction waiting to execute
  reg  [7:0]        work_reg;         // Working register
  reg  [7:0]        status_reg;       // C, Z, N, bad opcode
  reg  [3:0]        bank_reg;         // Bank select register
  reg  [7:0]        ctrl_reg;         // Extended set enable
  reg  [ADDR_W-1:0] index_reg;        // Literal offset base pointer
  reg  [ADDR_W-1:0] maddr_reg;        // Memory window address
  reg  [ADDR_W-1:0] eaddr_reg;        // Last resolved operand address

  // ==================================================================
  // Bus decode
  // One wait-free access cycle follows every setup cycle
  wire setup    = psel & ~penable;            // Setup cycle
  wire done     = psel & penable & pready;    // Transfer completes
  wire wr_done  = done & pwrite;              // Write takes effect
  reg  [31:0] rd_mux;                         // Read data select
  reg         mapped;                         // Address is decoded

  // ==================================================================
  // Execute datapath
  wire [1:0]        op_sel = op_decode(instr_reg);
  wire [ADDR_W-1:0] ex_addr = eff_addr(instr_reg[`BRU_BIT_A], instr_reg[7:0],
                                       bank_reg, ctrl_reg[`BRU_CTRL_EXT],
                                       index_reg);
  wire [7:0] ex_result;                       // Rotated value
  wire       ex_carry;                        // New carry
  wire       ex_neg;                          // New negative
  wire       ex_zero;                         // New zero
  // Unknown opcodes only raise the sticky status bit
  wire       ex_go  = pend_reg & (op_sel != `BRU_OP_NONE);
  wire       ex_bad = pend_reg & (op_sel == `BRU_OP_NONE);
  wire       ex_dst_f = instr_reg[`BRU_BIT_D];  // Destination select

  // Operand read combinationally from the resolved address
  bru_rotate u_rot
  (
    .op        (op_sel),
    .operand   (mem[ex_addr]),
    .carry_in  (status_reg[`BRU_ST_C]),
    .result    (ex_result),
    .carry_out (ex_carry),
    .neg_flag  (ex_neg),
    .zero_flag (ex_zero)
  );

  // ==================================================================
  // Read multiplexer
  // Unmapped offsets read zero and flag an error
  always @*
  begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `BRU_OFF_INSTR:      rd_mux[15:0]       = instr_reg;
      `BRU_OFF_WORK:       rd_mux[7:0]        = work_reg;
      `BRU_OFF_STATUS:     rd_mux[7:0]        = status_reg;
      `BRU_OFF_BANK_SEL:   rd_mux[3:0]        = bank_reg;
      `BRU_OFF_CTRL:       rd_mux[7:0]        = ctrl_reg;
      `BRU_OFF_INDEX_BASE: rd_mux[ADDR_W-1:0] = index_reg;
      `BRU_OFF_MEM_ADDR:   rd_mux[ADDR_W-1:0] = maddr_reg;
      `BRU_OFF_MEM_DATA:   rd_mux[7:0]        = mem[maddr_reg];
      `BRU_OFF_EFF_ADDR:   rd_mux[ADDR_W-1:0] = eaddr_reg;
      default:             mapped             = 1'b0;
    endcase
  end

  // ==================================================================
  // APB answer: ready in the first cycle of the access phase
  // Read data is loaded at setup and cleared when the transfer ends
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Idle answer during reset
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;   // Unmapped address errors
      if (setup && !pwrite)
        prdata <= rd_mux;
      else if (done)
        prdata <= 32'h0000_0000;
    end
  end

  // ==================================================================
  // Control registers and execution
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Every control register to its reset value
      instr_reg  <= 16'h0000;
      pend_reg   <= 1'b0;
      work_reg   <= `BRU_RST_WORK;
      status_reg <= `BRU_RST_STATUS;
      bank_reg   <= `BRU_RST_BANK;
      ctrl_reg   <= `BRU_RST_CTRL;
      index_reg  <= `BRU_RST_INDEX;
      maddr_reg  <= {ADDR_W{1'b0}};
      eaddr_reg  <= {ADDR_W{1'b0}};
    end
    else
    begin
      // Software writes
      if (wr_done)
      begin
        case (paddr)
          `BRU_OFF_INSTR:      instr_reg  <= pwdata[15:0];
          `BRU_OFF_WORK:       work_reg   <= pwdata[7:0];
          `BRU_OFF_STATUS:     status_reg <= pwdata[7:0];
          `BRU_OFF_BANK_SEL:   bank_reg   <= pwdata[3:0];
          `BRU_OFF_CTRL:       ctrl_reg   <= {7'h00, pwdata[0]};
          `BRU_OFF_INDEX_BASE: index_reg  <= pwdata[ADDR_W-1:0];
          `BRU_OFF_MEM_ADDR:   maddr_reg  <= pwdata[ADDR_W-1:0];
          // Operand address and unmapped offsets are not writable
          default:             ctrl_reg   <= ctrl_reg;
        endcase
      end
      // Instruction write arms one execute cycle
      pend_reg <= wr_done & (paddr == `BRU_OFF_INSTR);
      // Execute: hardware update wins over software
      if (ex_go)
      begin
        eaddr_reg <= ex_addr;
        if (!ex_dst_f)
          work_reg <= ex_result;
        status_reg[`BRU_ST_N] <= ex_neg;
        status_reg[`BRU_ST_Z] <= ex_zero;
        // Rotate left without carry leaves the carry flag alone
        if (op_sel != `BRU_OP_RLNC)
          status_reg[`BRU_ST_C] <= ex_carry;
      end
      else if (ex_bad)
        status_reg[`BRU_ST_BADOP] <= 1'b1;    // Unknown opcode sticky
    end
  end

  // ==================================================================
  // File memory writes: result write-back or software window
  // Write-back has priority; the bus cannot reach the window that cycle
  always @(posedge pclk)
  begin
    if (ex_go && ex_dst_f)
      mem[ex_addr] <= ex_result;
    else if (wr_done && paddr == `BRU_OFF_MEM_DATA)
      mem[maddr_reg] <= pwdata[7:0];
  end

endmodule

// ### verif/bru_top_sva.sv
// Checker of the APB answer of the byte rotate unit
`timescale 1ns/1ps

module bru_top_chk
(
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB request
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  // APB answer
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==================================================================
  // Setup cycle of a transfer
  sequence s_setup; psel && !penable; endsequence
  // A completing answer cycle
  sequence s_done; pready && psel && penable; endsequence
  property p_ans; s_setup |=> s_done; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  property p_map; pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  property p_unmap; pready && paddr > 8'h20 |-> pslverr; endproperty
  property p_hi; pready && !pwrite |-> prdata[31:16] == 16'h0; endproperty
  property p_one; pready |-> $past(psel) && !$past(penable); endproperty
  a_ans: assert property (p_ans) else $error("No answer after setup");
  a_pulse: assert property (p_pulse) else $error("Answer too long");
  a_err: assert property (p_err) else $error("Error without answer");
  a_idle: assert property (p_idle) else $error("Read data not idle");
  a_map: assert property (p_map) else $error("Mapped address refused");
  a_unmap: assert property (p_unmap) else $error("Unmapped accepted");
  a_hi: assert property (p_hi) else $error("Upper read bits set");
  a_one: assert property (p_one) else $error("Extra answer");
endmodule

bind bru_top bru_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ### verif/bru_top_tb.sv
// Self-checking bench of the byte rotate unit
`timescale 1ns/1ps
`include "bru_consts.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module bru_top_tb;
  // ==================================================================
  // Ports, model state and counters
  reg          pclk = 0;
  reg          presetn = 0;
  reg          psel = 0;
  reg          penable = 0;
  reg          pwrite = 0;
  reg  [7:0]   paddr = 0;
  reg  [31:0]  pwdata = 0;
  wire [31:0]  prdata;
  wire         pready;
  wire         pslverr;
  integer      fail_count = 0;
  integer      cmp_count = 0;
  integer      seed = 32'h26515FF0;
  integer      i;
  reg  [31:0]  r, q, rd;
  reg          err, ext, a, d, c, cn;
  reg  [3:0]   bank;
  reg  [11:0]  base, ea, exp_ea;
  reg  [7:0]   f, v, w0, res;
  reg  [1:0]   op;
  reg  [5:0]   opc [0:3];

  // Free running clock
  always #5 pclk = ~pclk;

  bru_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ==================================================================
  // One APB transfer, answer taken at the ready edge
  task xfer(input w, input [7:0] ad, input [31:0] dt);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= dt;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n = n + 1;
      end
      // Limit ran out: count it and end the run
      if (pready !== 1'b1)
      begin
        fail_count++;
        $display("[ERR] %0t no ready", $time);
        give_verdict;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
    end
  endtask

  // Expected carry and result of a rotate
  function [8:0] rot(input [1:0] o, input [7:0] x, input ci);
    case (o)
      2'h0: rot = {ci, x[6:0], x[7]};
      2'h1: rot = {x[0], ci, x[7:1]};
      default: rot = {x[7], x[6:0], ci};
    endcase
  endfunction

  // Expected operand address
  function [11:0] eff(input aa, input [7:0] ff);
    if (aa) eff = {bank, ff};
    else if (ext && ff <= 8'h5F) eff = base + ff;
    else eff = {(ff < 8'h60) ? 4'h0 : 4'hF, ff};
  endfunction

  // Expected status byte after an instruction
  function [7:0] exp_st(input [1:0] o, input [7:0] rs, input ci, input co);
    if (o == 2'h3)
      exp_st = {1'b1, 6'h00, ci};
    else
      exp_st = {5'h00, rs[7], rs == 8'h00, (o == 2'h0) ? ci : co};
  endfunction

  // Verdict and end of run
  task give_verdict;
    begin
      if (fail_count == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Watchdog against a hang
  initial
  begin
    #500000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict;
  end

  // ==================================================================
  // Main sequence
  initial
  begin
    opc[0] = `BRU_OPC_RLNC;
    opc[1] = `BRU_OPC_RRC;
    opc[2] = `BRU_OPC_RLC;
    opc[3] = 6'h3F;  // Undecoded opcode
    exp_ea = 12'h000;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    xfer(0, `BRU_OFF_STATUS, 0); `CHK(rd, 32'h0)
    xfer(0, 8'h24, 0); `CHK(err, 1'b1)
    xfer(1, `BRU_OFF_EFF_ADDR, 32'hFFF);
    xfer(0, `BRU_OFF_EFF_ADDR, 0); `CHK(rd, 32'h0)
    for (i = 0; i < 200; i = i + 1)
    begin
      r = $random(seed); q = $random(seed);
      op = r[1:0]; d = r[2]; a = r[3]; f = r[15:8]; bank = r[19:16]; ext = r[20];
      base = q[31:20]; v = q[7:0]; c = q[8]; w0 = q[19:12];
      // Literal offset limit either side
      if (i < 4)
      begin
        a = 0; ext = 1; f = 8'h5E + i;
      end
      // Known left rotate value
      if (i == 4)
      begin
        op = 0; v = 8'hAB;
      end
      ea = eff(a, f);
      xfer(1, `BRU_OFF_BANK_SEL, bank);
      xfer(1, `BRU_OFF_CTRL, ext);
      xfer(1, `BRU_OFF_INDEX_BASE, base);
      xfer(1, `BRU_OFF_MEM_ADDR, ea);
      xfer(1, `BRU_OFF_MEM_DATA, v);
      xfer(1, `BRU_OFF_STATUS, c);
      xfer(1, `BRU_OFF_WORK, w0);
      xfer(1, `BRU_OFF_INSTR, {opc[op], d, a, f});
      {cn, res} = rot(op, v, c);
      if (op != 3) exp_ea = ea;
      xfer(0, `BRU_OFF_WORK, 0);
      `CHK(rd[7:0], (op != 3 && !d) ? res : w0)
      xfer(0, `BRU_OFF_STATUS, 0);
      `CHK(rd[7:0], exp_st(op, res, c, cn))
      xfer(0, `BRU_OFF_EFF_ADDR, 0);
      `CHK(rd[11:0], exp_ea)
      xfer(0, `BRU_OFF_MEM_DATA, 0);
      `CHK(rd[7:0], (op != 3 && d) ? res : v)
    end
    give_verdict;
  end
endmodule
